// [core/bus_clock_divider_gate.sv]
// Bus clock divider, OTP clock gate and crystal trim register
//
// Functional notes
// - The bus clock enable divides the source by 1, 2, 4 or 8 per bits 1:0 of the control register.
// - The peripheral clock enable divides the bus clock enable further by 1, 2, 4 or 8 per bits 5:4.
// - The OTP controller clock runs only while control bit 7 is one, and that bit resets to zero.
// - An 8-bit crystal trim code resets to 0x80 and drives the oscillator, 0x00 fastest, 0xFF slowest.
`timescale 1ns/1ns
module bus_clock_divider_gate (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Derived clock enables
  output logic             hclk_en,
  output logic             pclk_en,
  output logic             otp_clk_en,
  // Oscillator trim
  output logic [7:0]       crystal_fine_trim_code
);

  // ----------------------------------------------------------------
  // Bus front end
  // ----------------------------------------------------------------
  clk_div_pkg::bus_req_t addr_req;
  clk_div_pkg::bus_req_t data_req;

  ahb_reg_port u_port (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .addr_req  (addr_req),
    .data_req  (data_req)
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  clk_div_pkg::bus_clock_control_t bus_clock_control;
  clk_div_pkg::bus_clock_control_t next_bus_clock_control;
  logic [7:0]                      crystal_fine_trim;
  logic [7:0]                      next_crystal_fine_trim;
  logic                            wr_ctrl;
  logic                            wr_trim;

  assign wr_ctrl = data_req.wr && (data_req.index == clk_div_pkg::CTRL_INDEX);
  assign wr_trim = data_req.wr && (data_req.index == clk_div_pkg::TRIM_INDEX);

  // Write data lands in the data phase; reads see it at once
  always_comb begin
    next_bus_clock_control = bus_clock_control;
    next_crystal_fine_trim = crystal_fine_trim;
    if (wr_ctrl) begin
      next_bus_clock_control = hwdata[clk_div_pkg::REG_W-1:0];
    end
    if (wr_trim) begin
      next_crystal_fine_trim = hwdata[clk_div_pkg::REG_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_clock_control <= clk_div_pkg::CTRL_RESET;
    end else begin
      bus_clock_control <= next_bus_clock_control;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      crystal_fine_trim <= clk_div_pkg::TRIM_RESET;
    end else begin
      crystal_fine_trim <= next_crystal_fine_trim;
    end
  end

  assign crystal_fine_trim_code = crystal_fine_trim;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Captured in the address phase so hrdata comes from a flip-flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_req.rd) begin
      case (addr_req.index)
        clk_div_pkg::CTRL_INDEX: begin
          hrdata <= {24'h00_0000, next_bus_clock_control};
        end
        clk_div_pkg::TRIM_INDEX: begin
          hrdata <= {24'h00_0000, next_crystal_fine_trim};
        end
        default: begin
          hrdata <= 32'h0000_0000;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Dividers
  // ----------------------------------------------------------------
  logic [clk_div_pkg::DIV_CODE_W-1:0] hclk_act;
  logic [clk_div_pkg::DIV_CODE_W-1:0] pclk_act;

  pow2_enable_divider #(
    .CODE_W (clk_div_pkg::DIV_CODE_W)
  ) u_hclk_div (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .en_in    (1'b1),
    .code     (bus_clock_control.hclk_div),
    .tick     (hclk_en),
    .act_code (hclk_act)
  );

  // Cascaded: counts bus clock enables, not source cycles
  pow2_enable_divider #(
    .CODE_W (clk_div_pkg::DIV_CODE_W)
  ) u_pclk_div (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .en_in    (hclk_en),
    .code     (bus_clock_control.pclk_div),
    .tick     (pclk_en),
    .act_code (pclk_act)
  );

  assign otp_clk_en = hclk_en && bus_clock_control.otp_enable;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  logic       ctrl_written;
  logic       trim_written;
  logic [3:0] hcnt;
  logic [3:0] scnt;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_written <= 1'b0;
      trim_written <= 1'b0;
    end else begin
      ctrl_written <= ctrl_written || wr_ctrl;
      trim_written <= trim_written || wr_trim;
    end
  end

  // Bus enables seen since the last peripheral enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hcnt <= 4'h0;
    end else if (pclk_en) begin
      hcnt <= 4'h0;
    end else if (hclk_en) begin
      hcnt <= hcnt + 4'h1;
    end
  end

  // Source cycles since the last bus enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scnt <= 4'h0;
    end else if (hclk_en) begin
      scnt <= 4'h0;
    end else begin
      scnt <= scnt + 4'h1;
    end
  end

  // Bus period matches the active code
  AST_HCLK_PERIOD: assert property (hclk_en |-> (scnt + 4'h1) == (4'h1 << hclk_act))
    else $error("bus clock period does not match divide code");

  // Divide by 8 leaves seven idle cycles
  AST_HCLK_DIV8: assert property (
    hclk_en && bus_clock_control.hclk_div == 2'h3 |=> !hclk_en [*7] ##1 hclk_en)
    else $error("bus clock divide by 8 period wrong");

  // Peripheral enable only with a bus enable
  AST_PCLK_CASCADE: assert property (pclk_en |-> hclk_en)
    else $error("peripheral enable without bus enable");

  // Peripheral period counted in bus enables
  AST_PCLK_PERIOD: assert property (pclk_en |-> (hcnt + 4'h1) == (4'h1 << pclk_act))
    else $error("peripheral period does not match divide code");

  // OTP clock off while gate bit is clear
  AST_OTP_GATED: assert property (!bus_clock_control.otp_enable |-> !otp_clk_en)
    else $error("OTP clock runs with gate bit clear");

  // Gate open at full rate runs the OTP clock next cycle
  AST_OTP_OPEN: assert property (
    wr_ctrl && hwdata[clk_div_pkg::OTP_ENABLE_BIT] && hclk_act == 2'h0 &&
    bus_clock_control.hclk_div == 2'h0 &&
    hwdata[clk_div_pkg::HCLK_DIV_LSB +: 2] == 2'h0 |=>
    otp_clk_en ##1 (otp_clk_en || !bus_clock_control.otp_enable))
    else $error("OTP clock did not start after gate set");

  AST_TRIM_RESET: assert property (!trim_written && !wr_trim |-> crystal_fine_trim_code == 8'h80)
    else $error("trim code left reset value unwritten");

  AST_TRIM_WRITE: assert property (wr_trim |=> crystal_fine_trim_code == $past(hwdata[7:0]))
    else $error("trim write not driven to oscillator");

  // Undivided until the control register is written
  AST_RESET_UNDIVIDED: assert property (!ctrl_written |-> hclk_en && pclk_en && !otp_clk_en)
    else $error("derived rates divided before any control write");

  // Active bus code moves only at a period end
  AST_HCLK_BOUNDARY: assert property ($changed(hclk_act) |-> $past(hclk_en))
    else $error("bus divide code changed mid period");

  // Active peripheral code moves only at a period end
  AST_PCLK_BOUNDARY: assert property ($changed(pclk_act) |-> $past(pclk_en))
    else $error("peripheral divide code changed mid period");

  // ----------------------------------------------------------------
  // Encoding, gate and update checks
  // ----------------------------------------------------------------
  // Code 0 ticks every cycle
  AST_HCLK_FULL_RATE: assert property (hclk_act == 2'h0 |-> hclk_en)
    else $error("bus clock skipped a cycle at divide by 1");

  // Divide by 2 leaves one idle cycle
  AST_HCLK_DIV2: assert property (
    hclk_en && bus_clock_control.hclk_div == 2'h1 |=> !hclk_en ##1 hclk_en)
    else $error("bus clock divide by 2 period wrong");

  // Divide by 4 leaves three idle cycles
  AST_HCLK_DIV4: assert property (
    hclk_en && bus_clock_control.hclk_div == 2'h2 |=> !hclk_en [*3] ##1 hclk_en)
    else $error("bus clock divide by 4 period wrong");

  // Counter bound catches a stalled divider
  AST_HCLK_NO_STALL: assert property (scnt <= 4'h7)
    else $error("bus clock enable stalled");

  // Code 0 passes every bus enable
  AST_PCLK_FULL_RATE: assert property (pclk_act == 2'h0 |-> pclk_en == hclk_en)
    else $error("peripheral enable dropped at divide by 1");

  // Counter bound catches a stalled divider
  AST_PCLK_NO_STALL: assert property (hcnt <= 4'h7)
    else $error("peripheral clock enable stalled");

  // Gate bit follows a control write
  AST_OTP_BIT_WRITE: assert property (
    wr_ctrl |=> bus_clock_control.otp_enable == $past(hwdata[clk_div_pkg::OTP_ENABLE_BIT]))
    else $error("OTP gate bit not written");

  // Open gate passes every bus enable
  AST_OTP_RUNS: assert property (bus_clock_control.otp_enable && hclk_en |-> otp_clk_en)
    else $error("OTP clock stopped with gate bit set");

  // Clearing the gate stops the clock next cycle
  AST_OTP_CLOSE: assert property (wr_ctrl && !hwdata[clk_div_pkg::OTP_ENABLE_BIT] |=> !otp_clk_en)
    else $error("OTP clock ran after gate cleared");

  // Control changes only by a write
  AST_CTRL_HOLDS: assert property (!wr_ctrl |=> $stable(bus_clock_control))
    else $error("control register changed without a write");

  // Trim changes only by a write
  AST_TRIM_HOLDS: assert property (!wr_trim |=> $stable(crystal_fine_trim_code))
    else $error("trim code changed without a write");

  // Bus divider takes the code at its boundary
  AST_HCLK_TAKES_CODE: assert property (hclk_en |=> hclk_act == $past(bus_clock_control.hclk_div))
    else $error("bus divider missed the new code at its boundary");

  // Peripheral divider takes the code at its boundary
  AST_PCLK_TAKES_CODE: assert property (pclk_en |=> pclk_act == $past(bus_clock_control.pclk_div))
    else $error("peripheral divider missed the new code at its boundary");

endmodule : bus_clock_divider_gate

// [shared/clk_div_pkg.sv]
// Constants and carrier types for the bus clock divider and gate block
package clk_div_pkg;

  // ----------------------------------------------------------------
  // Register indices and byte decode
  // ----------------------------------------------------------------
  // Printed register indices; byte address is four times the index
  localparam logic [31:0] CTRL_INDEX_PRINTED = 32'h5000_0000;
  localparam logic [31:0] TRIM_INDEX_PRINTED = 32'h5000_0002;
  localparam int          INDEX_W            = 10;
  // Index relative to the block base; decoded from haddr[11:2]
  localparam logic [INDEX_W-1:0] CTRL_INDEX =
    INDEX_W'(CTRL_INDEX_PRINTED - CTRL_INDEX_PRINTED);
  localparam logic [INDEX_W-1:0] TRIM_INDEX =
    INDEX_W'(TRIM_INDEX_PRINTED - CTRL_INDEX_PRINTED);
  localparam int          INDEX_LSB          = 2;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int          DIV_CODE_W         = 2;
  localparam int          OTP_ENABLE_BIT     = 7;
  localparam int          PCLK_DIV_LSB       = 4;
  localparam int          HCLK_DIV_LSB       = 0;
  localparam int          REG_W              = 8;
  localparam logic [7:0]  CTRL_RESET         = 8'h00;
  localparam logic [7:0]  TRIM_RESET         = 8'h80;

  // ----------------------------------------------------------------
  // Bus encodings and clock rate
  // ----------------------------------------------------------------
  localparam logic [1:0]  HTRANS_NONSEQ      = 2'h2;
  localparam logic        HRESP_OKAY         = 1'b0;
  localparam int          HCLK_FREQ_HZ       = 20_000_000;

  // Bus clock control register, bit 7 down to bit 0
  typedef struct packed {
    logic                  otp_enable;
    logic                  spare_6;
    logic [DIV_CODE_W-1:0] pclk_div;
    logic [1:0]            spare_3_2;
    logic [DIV_CODE_W-1:0] hclk_div;
  } bus_clock_control_t;

  // One decoded bus request
  typedef struct packed {
    logic               rd;
    logic               wr;
    logic [INDEX_W-1:0] index;
  } bus_req_t;

endpackage : clk_div_pkg

// [core/pow2_enable_divider.sv]
// Power-of-two clock enable divider with period-boundary code update
`timescale 1ns/1ns
module pow2_enable_divider #(
  parameter int CODE_W = 2
) (
  // Clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // Source rate and divide code
  input  wire logic              en_in,
  input  wire logic [CODE_W-1:0] code,
  // Divided rate
  output logic                   tick,
  output logic [CODE_W-1:0]      act_code
);

  localparam int CNT_W = (1 << CODE_W) - 1;

  if (CODE_W < 1 || CODE_W > 3) begin : g_check
    $error("pow2_enable_divider: CODE_W must be 1 to 3");
  end

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] last;

  always_comb begin
    last = '0;
    for (int i = 0; i < CNT_W; i++) begin
      if (i < int'(act_code)) begin
        last[i] = 1'b1;
      end
    end
  end

  assign tick = en_in && (cnt == last);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= '0;
    end else if (en_in) begin
      if (tick) begin
        cnt <= '0;
      end else begin
        cnt <= cnt + CNT_W'(1);
      end
    end
  end

  // New code only at end of a period, so no runt pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act_code <= '0;
    end else if (tick) begin
      act_code <= code;
    end
  end

endmodule : pow2_enable_divider

// [core/ahb_reg_port.sv]
// AHB-Lite slave front end: address decode and data-phase tracking
`timescale 1ns/1ns
module ahb_reg_port (
  // Clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // AHB-Lite slave side
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  // Decoded requests
  output clk_div_pkg::bus_req_t     addr_req,
  output clk_div_pkg::bus_req_t     data_req
);

  logic take;

  // Sequential bursts are not used here; only NONSEQ starts a transfer
  assign take = hsel && hready && (htrans == clk_div_pkg::HTRANS_NONSEQ);

  always_comb begin
    addr_req       = '0;
    addr_req.rd    = take && !hwrite;
    addr_req.wr    = take && hwrite;
    addr_req.index = haddr[clk_div_pkg::INDEX_LSB +: clk_div_pkg::INDEX_W];
  end

  // Never stalls: every transfer completes with zero wait states
  assign hreadyout = 1'b1;
  assign hresp     = clk_div_pkg::HRESP_OKAY;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_req <= '0;
    end else if (hready) begin
      data_req <= addr_req;
    end
  end

  logic unused_size;
  assign unused_size = ^hsize;

endmodule : ahb_reg_port

// [dv/testbench.sv]
// Self-checking bench for the bus clock divider and gate block
`timescale 1ns/1ns
module testbench;
  // ----------------------------------------------------------------
  // Stimulus and observation
  // ----------------------------------------------------------------
  localparam logic [31:0] CTRL_A = 32'(clk_div_pkg::CTRL_INDEX) << clk_div_pkg::INDEX_LSB;
  localparam logic [31:0] TRIM_A = 32'(clk_div_pkg::TRIM_INDEX) << clk_div_pkg::INDEX_LSB;
  localparam logic [31:0] HOLE_A = 32'h0000_0004;
  logic        hclk     = 1'b0;
  logic        hresetn  = 1'b0;
  logic        hsel     = 1'b0;
  logic [31:0] haddr    = 32'h0;
  logic [1:0]  htrans   = 2'h0;
  logic        hwrite   = 1'b0;
  logic [2:0]  hsize    = 3'h2;
  logic [31:0] hwdata   = 32'h0;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        hclk_en;
  logic        pclk_en;
  logic        otp_clk_en;
  logic [7:0]  crystal_fine_trim_code;
  int          n_errors    = 0;
  int          checks_done = 0;
  int          cycles      = 0;
  int          h_gap       = 0;
  int          p_gap       = 0;
  logic [7:0]  exp_ctrl    = 8'h00;
  logic [7:0]  exp_trim    = 8'h80;
  logic [1:0]  old_h       = 2'h0;
  logic        settled     = 1'b1;
  logic        h_seen      = 1'b0;
  logic        p_seen      = 1'b0;
  logic [31:0] rd;
  logic [31:0] w;

  bus_clock_divider_gate u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .hclk_en(hclk_en),
    .pclk_en(pclk_en), .otp_clk_en(otp_clk_en), .crystal_fine_trim_code(crystal_fine_trim_code)
  );

  always #25 hclk = ~hclk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] per(input logic [1:0] c);
    return 32'h1 << c;
  endfunction : per

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  // Single AHB-Lite transfer, zero or more wait states
  task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
                     output logic [31:0] rdat);
    hsel   <= 1'b1;
    haddr  <= addr;
    htrans <= clk_div_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    haddr  <= ~addr;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdat = hrdata;
    hwdata <= ~wd;
    chk({31'h0, hresp}, {31'h0, clk_div_pkg::HRESP_OKAY}, "hresp");
  endtask : bus

  task automatic wr_reg(input logic [31:0] addr, input logic [31:0] wd);
    logic [31:0] dummy;
    bus(1'b1, addr, wd, dummy);
    if (addr == CTRL_A) begin
      old_h    = exp_ctrl[1:0];
      exp_ctrl = wd[7:0];
    end else if (addr == TRIM_A) exp_trim = wd[7:0];
  endtask : wr_reg

  task automatic rd_chk(input logic [31:0] addr, input logic [31:0] exp, input string what);
    bus(1'b0, addr, $urandom, rd);
    chk(rd, exp, what);
  endtask : rd_chk

  // ----------------------------------------------------------------
  // Clock enable monitor
  // ----------------------------------------------------------------
  always @(negedge hclk) begin
    if (!hresetn) begin
      h_seen = 1'b0;
      p_seen = 1'b0;
    end else begin
      h_gap++;
      p_gap++;
      if (h_seen && h_gap > 8) chk(h_gap, 32'h8, "hclk stalled");
      if (p_seen && p_gap > 64) chk(p_gap, 32'h40, "pclk stalled");
      if (pclk_en === 1'b1) chk({31'h0, hclk_en}, 32'h1, "pclk off bus tick");
      chk({31'h0, otp_clk_en}, {31'h0, hclk_en & exp_ctrl[7]}, "otp gate");
      if (hclk_en === 1'b1) begin
        // Old period tolerated after a control write until old_h is refreshed to the new code
        if (h_seen) chk((h_gap == per(old_h)) ? per(exp_ctrl[1:0]) : h_gap, per(exp_ctrl[1:0]), "hclk period");
        h_gap  = 0;
        h_seen = 1'b1;
      end
      if (pclk_en === 1'b1) begin
        if (settled && p_seen) chk(p_gap, per(exp_ctrl[1:0]) * per(exp_ctrl[5:4]), "pclk period");
        p_gap  = 0;
        p_seen = settled;
      end
    end
  end

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 8000) begin
      n_errors++;
      $display("ERROR %0t timeout", $time);
      tally_and_finish;
    end
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(21733));
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk(CTRL_A, 32'h0, "ctrl reset");
    rd_chk(TRIM_A, 32'h80, "trim reset");
    chk({24'h0, crystal_fine_trim_code}, 32'h80, "trim port reset");
    $display("test reset done");
    // Extremes first, then random codes
    for (int i = 0; i < 4; i++) begin
      w = $urandom;
      if (i < 2) w[7:0] = (i == 0) ? 8'h00 : 8'hFF;
      wr_reg(TRIM_A, w);
      rd_chk(TRIM_A, {24'h0, w[7:0]}, "trim readback");
      chk({24'h0, crystal_fine_trim_code}, {24'h0, w[7:0]}, "trim port");
    end
    $display("test trim done");
    wr_reg(HOLE_A, $urandom);
    rd_chk(HOLE_A, 32'h0, "hole read");
    rd_chk(CTRL_A, {24'h0, exp_ctrl}, "ctrl after hole");
    rd_chk(TRIM_A, {24'h0, exp_trim}, "trim after hole");
    $display("test hole done");
    // Every divide code on both dividers, then random mixes
    for (int i = 0; i < 8; i++) begin
      w = $urandom;
      if (i < 4) begin
        w[1:0] = 2'(i);
        w[5:4] = 2'(i);
        // Gate opens at full rate first
        w[7]   = ~i[0];
      end
      settled = 1'b0;
      wr_reg(CTRL_A, w);
      rd_chk(CTRL_A, {24'h0, w[7:0]}, "ctrl readback");
      repeat (150) @(posedge hclk);
      old_h   = exp_ctrl[1:0];
      p_seen  = 1'b0;
      settled = 1'b1;
      repeat (140) @(posedge hclk);
    end
    $display("test dividers done");
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    exp_ctrl = 8'h00;
    old_h    = 2'h0;
    exp_trim = 8'h80;
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk(CTRL_A, 32'h0, "ctrl second reset");
    rd_chk(TRIM_A, 32'h80, "trim second reset");
    repeat (20) @(posedge hclk);
    $display("test second reset done");
    tally_and_finish;
  end
endmodule : testbench
